// ### logic/sensor_line_timing_monitor.sv
// Line pixel counter, valid pixel window, transfer pulse and strobe probe.
// Assumes an AXI4-Lite master on i_ref_clk and strobes synchronous to it.
//
// What this block does
// - Valid indication drops once the pixel count reaches the end value.
// - The end value is high register bits 5:0 above the whole low register.
// - The line end value is 14 bits, six high plus a low byte, range 0 to 16383.
// - At the line end count the line ends and the next starts at once.
// - Line length sets both integration time and transfer pulse spacing.
// - The window, line and probe registers reset to their listed defaults.
// - An active probe drives its strobe on the chosen output over normal mapping.
// - Probe bits 7:4 pick red, green or blue sample or clamp by codes 0 to 5.
// - Signal code 1111 disables probing and leaves outputs normal.
// - Probe bits 3:0 pick output one, two or three by codes 0, 1 and 2.
// - Valid indication starts when the pixel count reaches the start value.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "line_timing_defs.svh"

module sensor_line_timing_monitor #(
    parameter int CNT_W = 14
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [5:0]  i_strobes,
    input  wire logic [2:0]  i_ctrl_normal,
    output logic [2:0]       o_sensor_ctrl_out,
    output logic             o_sensor_transfer_pulse,
    output logic             o_valid_pixel,
    output logic [CNT_W-1:0] o_pixel_count
);

    ////////////////////////////////////////////////////////////////////////////
    // Register file and AXI4-Lite slave.

    logic [7:0]  vs_hi_r, vs_lo_r, ve_hi_r, ve_lo_r, ll_hi_r, ll_lo_r, probe_r;
    logic [7:0]  vs_hi_nxt, vs_lo_nxt, ve_hi_nxt, ve_lo_nxt, ll_hi_nxt, ll_lo_nxt, probe_nxt;
    logic        aw_got_r, w_got_r, bvalid_r, rvalid_r;
    logic        aw_got_nxt, w_got_nxt, bvalid_nxt, rvalid_nxt;
    logic [7:0]  awaddr_r, awaddr_nxt;
    logic [7:0]  wdata_r, wdata_nxt;
    logic        wstrb_r, wstrb_nxt;
    logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        do_write;
    logic [CNT_W-1:0] count_r, count_nxt;
    logic        valid_r, valid_nxt, pulse_r, pulse_nxt;
    logic [2:0]  ctrl_r, ctrl_nxt;
    logic [CNT_W-1:0] vstart, vend, lend;

    // Address and data may come in either order; each is held until both are in.
    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready  = !w_got_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    // Built from held flags and live handshakes only, so the decode cannot loop on itself.
    assign do_write      = (aw_got_r || (s_axi_awvalid && s_axi_awready))
                           && (w_got_r || (s_axi_wvalid && s_axi_wready)) && !bvalid_r;

    // Channel capture and register updates; only byte lane 0 carries data.
    always_comb
    begin
        aw_got_nxt = aw_got_r;
        w_got_nxt  = w_got_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt  = wdata_r;
        wstrb_nxt  = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt  = bresp_r;
        vs_hi_nxt  = vs_hi_r;
        vs_lo_nxt  = vs_lo_r;
        ve_hi_nxt  = ve_hi_r;
        ve_lo_nxt  = ve_lo_r;
        ll_hi_nxt  = ll_hi_r;
        ll_lo_nxt  = ll_lo_r;
        probe_nxt  = probe_r;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_got_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_got_nxt = 1'b1;
            wdata_nxt = s_axi_wdata[7:0];
            wstrb_nxt = s_axi_wstrb[0];
        end
        if (bvalid_r && s_axi_bready)
        begin
            bvalid_nxt = 1'b0;
        end
        if (do_write)
        begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = `LT_AXI_OKAY;
            case (awaddr_nxt[7:2])
                `LT_OFF_VALID_START_HIGH: if (wstrb_nxt) vs_hi_nxt = wdata_nxt;
                `LT_OFF_VALID_START_LOW:  if (wstrb_nxt) vs_lo_nxt = wdata_nxt;
                `LT_OFF_VALID_END_HIGH:   if (wstrb_nxt) ve_hi_nxt = wdata_nxt;
                `LT_OFF_VALID_END_LOW:    if (wstrb_nxt) ve_lo_nxt = wdata_nxt;
                `LT_OFF_LINE_LEN_HIGH:    if (wstrb_nxt) ll_hi_nxt = wdata_nxt;
                `LT_OFF_LINE_LEN_LOW:     if (wstrb_nxt) ll_lo_nxt = wdata_nxt;
                `LT_OFF_PROBE_SEL_ONE:    if (wstrb_nxt) probe_nxt = wdata_nxt;
                `LT_OFF_STATUS:           bresp_nxt = `LT_AXI_OKAY;
                default:                  bresp_nxt = `LT_AXI_SLVERR;
            endcase
        end
    end

    // Read channel; the answer follows the address by one cycle.
    always_comb
    begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (rvalid_r && s_axi_rready)
        begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = `LT_AXI_OKAY;
            rdata_nxt  = 32'h0000_0000;
            case (s_axi_araddr[7:2])
                `LT_OFF_VALID_START_HIGH: rdata_nxt[7:0] = vs_hi_r;
                `LT_OFF_VALID_START_LOW:  rdata_nxt[7:0] = vs_lo_r;
                `LT_OFF_VALID_END_HIGH:   rdata_nxt[7:0] = ve_hi_r;
                `LT_OFF_VALID_END_LOW:    rdata_nxt[7:0] = ve_lo_r;
                `LT_OFF_LINE_LEN_HIGH:    rdata_nxt[7:0] = ll_hi_r;
                `LT_OFF_LINE_LEN_LOW:     rdata_nxt[7:0] = ll_lo_r;
                `LT_OFF_PROBE_SEL_ONE:    rdata_nxt[7:0] = probe_r;
                `LT_OFF_STATUS:           rdata_nxt = {16'h0000, valid_r, 1'b0, count_r};
                default:                  rresp_nxt = `LT_AXI_SLVERR;
            endcase
        end
    end

    // Register state; reset loads the documented defaults.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            vs_hi_r  <= `LT_RST_VALID_START_HIGH;
            vs_lo_r  <= `LT_RST_VALID_START_LOW;
            ve_hi_r  <= `LT_RST_VALID_END_HIGH;
            ve_lo_r  <= `LT_RST_VALID_END_LOW;
            ll_hi_r  <= `LT_RST_LINE_LEN_HIGH;
            ll_lo_r  <= `LT_RST_LINE_LEN_LOW;
            probe_r  <= `LT_RST_PROBE_SEL_ONE;
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r  <= 8'h00;
            wstrb_r  <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r  <= 2'h0;
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= 2'h0;
        end
        else
        begin
            vs_hi_r  <= vs_hi_nxt;
            vs_lo_r  <= vs_lo_nxt;
            ve_hi_r  <= ve_hi_nxt;
            ve_lo_r  <= ve_lo_nxt;
            ll_hi_r  <= ll_hi_nxt;
            ll_lo_r  <= ll_lo_nxt;
            probe_r  <= probe_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r  <= w_got_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r  <= wdata_nxt;
            wstrb_r  <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r  <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r  <= rdata_nxt;
            rresp_r  <= rresp_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line timing.

    // Reserved high bits are stored but ignored, so a careless write cannot stretch a line.
    assign vstart = {vs_hi_r[`LT_HIGH_FIELD_MSB:0], vs_lo_r};
    assign vend   = {ve_hi_r[`LT_HIGH_FIELD_MSB:0], ve_lo_r};
    assign lend   = {ll_hi_r[`LT_HIGH_FIELD_MSB:0], ll_lo_r};

    // Counter wraps at the line end; the window is judged on the next count.
    always_comb
    begin
        if (count_r >= lend)
        begin
            count_nxt = '0;
            pulse_nxt = 1'b1;
        end
        else
        begin
            count_nxt = count_r + 1'b1;
            pulse_nxt = 1'b0;
        end
        valid_nxt = (count_nxt >= vstart) && (count_nxt < vend);
    end

    // Probe routing; an active probe overrides the normal mapping of one pin.
    always_comb
    begin
        logic [3:0] sig;
        logic [3:0] pin;
        logic       strobe;
        sig      = probe_r[`LT_SIG_FIELD_MSB:`LT_SIG_FIELD_LSB];
        pin      = probe_r[`LT_PIN_FIELD_MSB:`LT_PIN_FIELD_LSB];
        strobe   = 1'b0;
        ctrl_nxt = i_ctrl_normal;
        case (sig)
            line_timing_pkg::SIG_SAMPLE_RED:   strobe = i_strobes[0];
            line_timing_pkg::SIG_CLAMP_RED:    strobe = i_strobes[1];
            line_timing_pkg::SIG_SAMPLE_GREEN: strobe = i_strobes[2];
            line_timing_pkg::SIG_CLAMP_GREEN:  strobe = i_strobes[3];
            line_timing_pkg::SIG_SAMPLE_BLUE:  strobe = i_strobes[4];
            line_timing_pkg::SIG_CLAMP_BLUE:   strobe = i_strobes[5];
            default:                           strobe = 1'b0;
        endcase
        if (sig <= line_timing_pkg::SIG_CLAMP_BLUE)
        begin
            case (pin)
                `LT_PIN_OUT_1: ctrl_nxt[0] = strobe;
                `LT_PIN_OUT_2: ctrl_nxt[1] = strobe;
                `LT_PIN_OUT_3: ctrl_nxt[2] = strobe;
                default:       ctrl_nxt = i_ctrl_normal;
            endcase
        end
    end

    // Timing state registers.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            count_r <= '0;
            valid_r <= 1'b0;
            pulse_r <= 1'b0;
            ctrl_r  <= 3'h0;
        end
        else
        begin
            count_r <= count_nxt;
            valid_r <= valid_nxt;
            pulse_r <= pulse_nxt;
            ctrl_r  <= ctrl_nxt;
        end
    end

    assign o_pixel_count           = count_r;
    assign o_valid_pixel           = valid_r;
    assign o_sensor_transfer_pulse = pulse_r;
    assign o_sensor_ctrl_out       = ctrl_r;

endmodule : sensor_line_timing_monitor

// ### logic/line_timing_defs.svh
// Offsets, field positions and reset values of the line timing monitor.
// Assumes inclusion by bare name from a file that needs the constants.
`ifndef LINE_TIMING_DEFS_SVH
`define LINE_TIMING_DEFS_SVH
// Register indices; the byte address on the bus is four times the index.
`define LT_OFF_VALID_START_HIGH 6'h06
`define LT_OFF_VALID_START_LOW  6'h07
`define LT_OFF_VALID_END_HIGH   6'h08
`define LT_OFF_VALID_END_LOW    6'h09
`define LT_OFF_LINE_LEN_HIGH    6'h0A
`define LT_OFF_LINE_LEN_LOW     6'h0B
`define LT_OFF_PROBE_SEL_ONE    6'h0C
`define LT_OFF_STATUS           6'h0D
`define LT_RST_VALID_START_HIGH 8'h00
`define LT_RST_VALID_START_LOW  8'h00
`define LT_RST_VALID_END_HIGH   8'h3F
`define LT_RST_VALID_END_LOW    8'hFE
`define LT_RST_LINE_LEN_HIGH    8'h3F
`define LT_RST_LINE_LEN_LOW     8'hFF
`define LT_RST_PROBE_SEL_ONE    8'hFF
`define LT_HIGH_FIELD_MSB       5
`define LT_SIG_FIELD_MSB        7
`define LT_SIG_FIELD_LSB        4
`define LT_PIN_FIELD_MSB        3
`define LT_PIN_FIELD_LSB        0
`define LT_SIG_NONE             4'hF
`define LT_PIN_OUT_1            4'h0
`define LT_PIN_OUT_2            4'h1
`define LT_PIN_OUT_3            4'h2
`define LT_AXI_OKAY             2'h0
`define LT_AXI_SLVERR           2'h2
`endif

// ### logic/line_timing_pkg.sv
// Types shared by the line timing monitor.
// Assumes nothing beyond a SystemVerilog compiler.
package line_timing_pkg;
    typedef enum logic [3:0] {
        SIG_SAMPLE_RED   = 4'h0,
        SIG_CLAMP_RED    = 4'h1,
        SIG_SAMPLE_GREEN = 4'h2,
        SIG_CLAMP_GREEN  = 4'h3,
        SIG_SAMPLE_BLUE  = 4'h4,
        SIG_CLAMP_BLUE   = 4'h5
    } probe_sig_t;
endpackage : line_timing_pkg

// ### tb/line_timing_sva.sv
// Port checker of the line timing monitor: bus answers and the line counter.
// Assumes a bind onto the top module, every port under its own name.
`timescale 1ns/1ps
module line_timing_sva #(
    parameter int CNT_W = 14
) (
    input wire logic             i_ref_clk,
    input wire logic             i_rstn,
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_awready,
    input wire logic             s_axi_wvalid,
    input wire logic             s_axi_wready,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_bready,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic             s_axi_rvalid,
    input wire logic             s_axi_rready,
    input wire logic             o_sensor_transfer_pulse,
    input wire logic [CNT_W-1:0] o_pixel_count
);
    // One clock domain, so clock and reset are given once for every check.
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    a_count_step: assert property (o_pixel_count != 0 |->
        o_pixel_count == $past(o_pixel_count) + 1) else $error("pixel count skipped");
    a_pulse_wrap: assert property (o_sensor_transfer_pulse ==
        (o_pixel_count == 0 && $past(o_pixel_count) != 0)) else $error("pulse off wrap");
    a_pulse_single: assert property (o_sensor_transfer_pulse |=> !o_sensor_transfer_pulse)
        else $error("pulse too long");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    a_wr_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_rd_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
endmodule : line_timing_sva

// ### tb/sensor_model.sv
// Sensor side model: times the gap between transfer pulses and counts lines.
// Assumes a one-cycle pulse on the pixel clock.
`timescale 1ns/1ps
module sensor_model (
    input  wire logic   i_clk,
    input  wire logic   i_rstn,
    input  wire logic   i_pulse,
    output logic [15:0] o_period,
    output logic [15:0] o_lines
);
    logic [15:0] gap_r;
    // Each pulse closes one integration period, so the gap is the line time.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            gap_r    <= 16'h0001;
            o_period <= 16'h0000;
            o_lines  <= 16'h0000;
        end
        else if (i_pulse)
        begin
            gap_r    <= 16'h0001;
            o_period <= gap_r;
            o_lines  <= o_lines + 16'h0001;
        end
        else
            gap_r <= gap_r + 16'h0001;
    end
endmodule : sensor_model

// ### tb/sensor_line_timing_monitor_test.sv
// Bench for the line timing monitor: registers, window, line length, probe.
// Assumes the design, its header and the sensor model are compiled first.
`timescale 1ns/1ps
`include "line_timing_defs.svh"
module sensor_line_timing_monitor_test;
    localparam logic [55:0] RST = 56'h00003FFE3FFFFF;
    logic        i_ref_clk, i_rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, o_sensor_transfer_pulse, o_valid_pixel;
    logic        win_on = 1'b0, pr_on = 1'b0;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, prb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [5:0]  i_strobes, p_str;
    logic [2:0]  i_ctrl_normal, o_sensor_ctrl_out, p_nrm;
    logic [13:0] o_pixel_count, vs, ve, ll;
    logic [15:0] period, lines, l0;
    logic [33:0] exp_q[$];
    logic [1:0]  exp_b[$];
    int          failures = 0, total_checks = 0, cyc = 0, seed = 32'hDB6207AF;
    sensor_line_timing_monitor #(.CNT_W(14)) dut_u (.i_ref_clk, .i_rstn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .i_strobes, .i_ctrl_normal, .o_sensor_ctrl_out,
        .o_sensor_transfer_pulse, .o_valid_pixel, .o_pixel_count);
    sensor_model ssr_u (.i_clk(i_ref_clk), .i_rstn, .i_pulse(o_sensor_transfer_pulse),
        .o_period(period), .o_lines(lines));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [33:0] seen, input logic [33:0] want);
        total_checks++;
        if (seen !== want)
        begin
            failures++;
            $display("mismatch t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic results();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results
    // Address and data go out together; each is dropped at the edge it is taken.
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] r = `LT_AXI_OKAY);
        logic ad, wd;
        exp_b.push_back(r);
        ad = 1'b0;
        wd = 1'b0;
        @(posedge i_ref_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!(ad && wd))
        begin
            @(posedge i_ref_clk);
            ad = ad | s_axi_awready;
            wd = wd | s_axi_wready;
            s_axi_awvalid <= !ad;
            s_axi_wvalid  <= !wd;
        end
        do @(posedge i_ref_clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr
    // The expected answer is noted before the request leaves.
    task automatic rd(input logic [7:0] a, input logic [33:0] want);
        exp_q.push_back(want);
        @(posedge i_ref_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge i_ref_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge i_ref_clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : rd
    // Pins other than the three outputs and codes above five leave levels normal.
    function automatic logic [2:0] exp_ctrl(logic [5:0] s, logic [2:0] n, logic [7:0] p);
        logic [2:0] e;
        e = n;
        if (p[7:4] <= 4'h5 && p[3:0] <= 4'h2)
            e[p[1:0]] = s[p[6:4]];
        return e;
    endfunction : exp_ctrl
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        i_ref_clk = 1'b0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end
    // New random strobes each cycle; the shadow keeps the pair the outputs reflect.
    always @(posedge i_ref_clk)
    begin
        p_str <= i_strobes;
        p_nrm <= i_ctrl_normal;
        i_strobes <= 6'($random(seed));
        i_ctrl_normal <= 3'($random(seed));
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures++;
            results();
        end
    end
    // Read and write answers are matched in order against the notes of the drivers.
    always @(posedge i_ref_clk)
    begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
            check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
            check(34'(s_axi_bresp), 34'(exp_b.pop_front()));
    end
    // Settled outputs are compared at the falling edge, clear of the launch edge.
    always @(negedge i_ref_clk)
    begin
        if (win_on)
            check(34'(o_valid_pixel), 34'(o_pixel_count >= vs && o_pixel_count < ve));
        if (win_on)
            check(34'(o_pixel_count <= ll), 34'h1);
        if (pr_on)
            check(34'(o_sensor_ctrl_out), 34'(exp_ctrl(p_str, p_nrm, prb)));
    end
    initial
    begin
        i_rstn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, i_strobes, i_ctrl_normal} = 57'h0;
        repeat (16) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        for (int k = 0; k < 7; k++)
            rd(8'(8'h18 + 4 * k), {26'h0, RST[55 - 8 * k -: 8]});
        rd(8'h3C, {`LT_AXI_SLVERR, 32'h0});
        wr(8'h3C, 8'hA5, `LT_AXI_SLVERR);
        $display("test registers done");
        // The end and line values reach into the high byte, setting bit 8 only of its six bits.
        vs = {8'h00, 6'($random(seed))};
        ve = {6'h01, 3'h0, 5'($random(seed))};
        ll = {6'h01, 4'h2, 4'($random(seed))};
        wr(8'h18, 8'(vs[13:8]));
        wr(8'h1C, vs[7:0]);
        wr(8'h20, 8'(ve[13:8]));
        wr(8'h24, ve[7:0]);
        wr(8'h28, 8'(ll[13:8]));
        wr(8'h2C, ll[7:0]);
        l0 = lines;
        while (lines != l0 + 16'h0001) @(posedge i_ref_clk);
        win_on = 1'b1;
        while (lines != l0 + 16'h0003) @(posedge i_ref_clk);
        check(34'(period), 34'(ll) + 34'h1);
        win_on = 1'b0;
        $display("test line done");
        for (int s = 0; s < 7; s++)
            for (int p = 0; p < 4; p++)
            begin
                pr_on = 1'b0;
                prb = {(s == 6) ? `LT_SIG_NONE : 4'(s), 4'(p)};
                wr(8'h30, prb);
                pr_on = 1'b1;
                repeat (16) @(posedge i_ref_clk);
            end
        pr_on = 1'b0;
        $display("test probe done");
        results();
    end
endmodule : sensor_line_timing_monitor_test
bind sensor_line_timing_monitor line_timing_sva #(.CNT_W(CNT_W)) sva_u (.i_ref_clk, .i_rstn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .o_sensor_transfer_pulse, .o_pixel_count);
